// *** include/hpirm_cfg.svh ***
// Offsets, bit positions and reset values for the host port routing and mailbox block.
// Assumes 16-bit word registers addressed by their printed byte address.
`ifndef HPIRM_CFG_SVH
`define HPIRM_CFG_SVH

`define HPIRM_ADDR_ROUTE   16'h0142
`define HPIRM_ADDR_MSG1    16'h0144
`define HPIRM_ADDR_MSG2    16'h0148
`define HPIRM_ADDR_MBX     16'hC0C6

`define HPIRM_ROUTE_RST    16'h1400
`define HPIRM_MBX_RST      16'h0000

// Routing register bit positions
`define HPIRM_RT_SOF2_HOST 13
`define HPIRM_RT_SOF2_CPU  12
`define HPIRM_RT_SOF1_HOST 11
`define HPIRM_RT_SOF1_CPU  10
`define HPIRM_RT_RST2_HOST 9
`define HPIRM_RT_SWAP_HI   8
`define HPIRM_RT_RES2_HOST 7
`define HPIRM_RT_RES1_HOST 6
`define HPIRM_RT_DON2_HOST 3
`define HPIRM_RT_DON1_HOST 2
`define HPIRM_RT_RST1_HOST 1
`define HPIRM_RT_SWAP_LO   0

// Status port bit positions
`define HPIRM_ST_SUPPLY    15
`define HPIRM_ST_IDENT     14
`define HPIRM_ST_SOF2      12
`define HPIRM_ST_SOF1      10
`define HPIRM_ST_RST2      9
`define HPIRM_ST_MBX_IN    8
`define HPIRM_ST_RES2      7
`define HPIRM_ST_RES1      6
`define HPIRM_ST_MSG2      5
`define HPIRM_ST_MSG1      4
`define HPIRM_ST_DON2      3
`define HPIRM_ST_DON1      2
`define HPIRM_ST_RST1      1
`define HPIRM_ST_MBX_OUT   0

`endif

// *** include/hpirm_pkg.sv ***
// Types shared by the host port routing and mailbox block.
// Assumes the constants header supplies all numeric values.
package hpirm_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hpirm_cpu_req_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        status_rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hpirm_host_req_t;

  // Pending levels from the serial engines
  typedef struct packed {
    logic sof2;
    logic sof1;
    logic reset2;
    logic reset1;
    logic resume2;
    logic resume1;
    logic done2;
    logic done1;
  } hpirm_eng_evt_t;

  typedef struct packed {
    hpirm_eng_evt_t eng;
    logic           mbx_rx;
    logic           mbx_tx;
  } hpirm_cpu_irq_t;

  typedef struct packed {
    logic [15:0]    route;
    logic [15:0]    msg1_data;
    logic [15:0]    msg2_data;
    logic [15:0]    mbx_in;
    logic [15:0]    mbx_out;
    logic           in_flag;
    logic           out_flag;
    logic           msg1_flag;
    logic           msg2_flag;
    logic [15:0]    cpu_rdata;
    logic [15:0]    host_rdata;
    logic           host_irq;
    hpirm_cpu_irq_t cpu_irq;
  } hpirm_state_t;

endpackage : hpirm_pkg

// *** logic/hpirm_swap.sv ***
// Byte lane swap between the internal word and the host port data lines.
// Assumes the two swap control bits are kept equal by software.
`timescale 1ns/1ns
module hpirm_swap
(
  input  wire logic [15:0] word_in,
  input  wire logic        swap_en,
  output logic      [15:0] word_out
);

  always_comb
  begin
    if (swap_en)
    begin
      word_out = {word_in[7:0], word_in[15:8]};
    end
    else
    begin
      word_out = word_in;
    end
  end

endmodule : hpirm_swap

// *** logic/hpirm_top.sv ***
// Interrupt routing, byte swap, message flags and mailbox between the
// on-chip CPU and the external host port.
// Assumes both request ports and all engine levels are synchronous to clock.
`timescale 1ns/1ns
`include "hpirm_cfg.svh"

// Notes on behaviour
// - Route bit 11 sends frame irq 1 to host
// - Route bit 10 sends frame irq 1 to CPU
// - Route bit 9 moves reset 2 to host
// - Route bit 1 moves reset 1 to host
// - Route bits 7,6 move resume 2,1 to host
// - Route bit 3 moves done 2 to host
// - Route bit 2 moves done 1 to host
// - Swap 00 straight lanes, 11 exchanged lanes
// - CPU message write sets flag and host irq
// - Host read of message clears its flag
// - Host mailbox write raises CPU receive irq
// - CPU mailbox read clears receive irq
// - Host mailbox read raises CPU transmit irq
// - CPU mailbox write clears transmit irq
// - CPU mailbox write asserts host irq pin
// - Status reads never touch the CPU side
// - Status 15 supply valid, 14 identity pin
// - Status bits 12,10,9,7,6,3,2,1 show pending irqs
// - Status 8 incoming mail, CPU read clears
// - Status 0 outgoing mail, host read clears
// - Status 5,4 show message writes pending
// - CPU reads routing, host reads and writes
module hpirm_top
(
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire hpirm_pkg::hpirm_cpu_req_t   cpu_req,
  output logic      [15:0]                 cpu_rdata,
  input  wire hpirm_pkg::hpirm_host_req_t  host_req,
  output logic      [15:0]                 host_rdata,
  output logic                             host_port_irq,
  input  wire hpirm_pkg::hpirm_eng_evt_t   eng_evt,
  input  wire logic                        mbx_rx_irq_en,
  input  wire logic                        mbx_tx_irq_en,
  input  wire logic                        supply_valid_status,
  input  wire logic                        otg_identity_status,
  output hpirm_pkg::hpirm_cpu_irq_t        cpu_irq
);

  localparam int ST_W = $bits(hpirm_pkg::hpirm_state_t);

  // Routing register sits in the top bits of the state word
  localparam hpirm_pkg::hpirm_state_t ST_RST =
    hpirm_pkg::hpirm_state_t'({`HPIRM_ROUTE_RST, {(ST_W - 16){1'b0}}});

  hpirm_pkg::hpirm_state_t st_q;
  hpirm_pkg::hpirm_state_t st_d;

  logic        swap_en;
  logic [15:0] host_wdata_sw;
  logic [15:0] host_raw;
  logic [15:0] host_raw_sw;
  logic [15:0] status_word;

  logic cpu_wr_msg1;
  logic cpu_wr_msg2;
  logic cpu_wr_mbx;
  logic cpu_rd_mbx;
  logic host_wr_mbx;
  logic host_rd_mbx;
  logic host_rd_msg1;
  logic host_rd_msg2;
  logic host_wr_route;

  // Engine levels that the routing hands to the host port
  function automatic hpirm_pkg::hpirm_eng_evt_t to_host
  (
    input logic [15:0]               rt,
    input hpirm_pkg::hpirm_eng_evt_t ev
  );
    hpirm_pkg::hpirm_eng_evt_t r;
    r         = '0;
    r.sof2    = ev.sof2    & rt[`HPIRM_RT_SOF2_HOST];
    r.sof1    = ev.sof1    & rt[`HPIRM_RT_SOF1_HOST];
    r.reset2  = ev.reset2  & rt[`HPIRM_RT_RST2_HOST];
    r.reset1  = ev.reset1  & rt[`HPIRM_RT_RST1_HOST];
    r.resume2 = ev.resume2 & rt[`HPIRM_RT_RES2_HOST];
    r.resume1 = ev.resume1 & rt[`HPIRM_RT_RES1_HOST];
    r.done2   = ev.done2   & rt[`HPIRM_RT_DON2_HOST];
    r.done1   = ev.done1   & rt[`HPIRM_RT_DON1_HOST];
    return r;
  endfunction : to_host

  // Frame irqs have their own CPU enable and may go both ways at once;
  // the others stay with the CPU unless taken by the host port.
  function automatic hpirm_pkg::hpirm_eng_evt_t to_cpu
  (
    input logic [15:0]               rt,
    input hpirm_pkg::hpirm_eng_evt_t ev
  );
    hpirm_pkg::hpirm_eng_evt_t r;
    r         = '0;
    r.sof2    = ev.sof2    & rt[`HPIRM_RT_SOF2_CPU];
    r.sof1    = ev.sof1    & rt[`HPIRM_RT_SOF1_CPU];
    r.reset2  = ev.reset2  & ~rt[`HPIRM_RT_RST2_HOST];
    r.reset1  = ev.reset1  & ~rt[`HPIRM_RT_RST1_HOST];
    r.resume2 = ev.resume2 & ~rt[`HPIRM_RT_RES2_HOST];
    r.resume1 = ev.resume1 & ~rt[`HPIRM_RT_RES1_HOST];
    r.done2   = ev.done2   & ~rt[`HPIRM_RT_DON2_HOST];
    r.done1   = ev.done1   & ~rt[`HPIRM_RT_DON1_HOST];
    return r;
  endfunction : to_cpu

  // Host side read of an addressed register, before the lane swap
  function automatic logic [15:0] host_read
  (
    input logic [15:0]             a,
    input hpirm_pkg::hpirm_state_t s
  );
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      `HPIRM_ADDR_ROUTE: r = s.route;
      `HPIRM_ADDR_MSG1:  r = s.msg1_data;
      `HPIRM_ADDR_MSG2:  r = s.msg2_data;
      `HPIRM_ADDR_MBX:   r = s.mbx_out;
      default:           r = 16'h0000;
    endcase
    return r;
  endfunction : host_read

  assign cpu_wr_msg1   = cpu_req.wr && cpu_req.addr == `HPIRM_ADDR_MSG1;
  assign cpu_wr_msg2   = cpu_req.wr && cpu_req.addr == `HPIRM_ADDR_MSG2;
  assign cpu_wr_mbx    = cpu_req.wr && cpu_req.addr == `HPIRM_ADDR_MBX;
  assign cpu_rd_mbx    = cpu_req.rd && cpu_req.addr == `HPIRM_ADDR_MBX;
  assign host_wr_mbx   = host_req.wr && host_req.addr == `HPIRM_ADDR_MBX;
  assign host_rd_mbx   = host_req.rd && host_req.addr == `HPIRM_ADDR_MBX;
  assign host_rd_msg1  = host_req.rd && host_req.addr == `HPIRM_ADDR_MSG1;
  assign host_rd_msg2  = host_req.rd && host_req.addr == `HPIRM_ADDR_MSG2;
  assign host_wr_route = host_req.wr && host_req.addr == `HPIRM_ADDR_ROUTE;

  // Mixed swap settings are illegal; the upper bit alone decides
  assign swap_en = st_q.route[`HPIRM_RT_SWAP_HI];

  // Status word is built from live levels so polling sees no lag
  always_comb
  begin
    status_word                     = 16'h0000;
    status_word[`HPIRM_ST_SUPPLY]   = supply_valid_status;
    status_word[`HPIRM_ST_IDENT]    = otg_identity_status;
    status_word[`HPIRM_ST_SOF2]     = eng_evt.sof2;
    status_word[`HPIRM_ST_SOF1]     = eng_evt.sof1;
    status_word[`HPIRM_ST_RST2]     = eng_evt.reset2;
    status_word[`HPIRM_ST_MBX_IN]   = st_q.in_flag;
    status_word[`HPIRM_ST_RES2]     = eng_evt.resume2;
    status_word[`HPIRM_ST_RES1]     = eng_evt.resume1;
    status_word[`HPIRM_ST_MSG2]     = st_q.msg2_flag;
    status_word[`HPIRM_ST_MSG1]     = st_q.msg1_flag;
    status_word[`HPIRM_ST_DON2]     = eng_evt.done2;
    status_word[`HPIRM_ST_DON1]     = eng_evt.done1;
    status_word[`HPIRM_ST_RST1]     = eng_evt.reset1;
    status_word[`HPIRM_ST_MBX_OUT]  = st_q.out_flag;
  end

  assign host_raw = host_req.status_rd ? status_word : host_read(host_req.addr, st_q);

  hpirm_swap u_swap_rd
  (
    .word_in  (host_raw),
    .swap_en  (swap_en),
    .word_out (host_raw_sw)
  );

  hpirm_swap u_swap_wr
  (
    .word_in  (host_req.wdata),
    .swap_en  (swap_en),
    .word_out (host_wdata_sw)
  );

  always_comb
  begin
    st_d = st_q;

    // Routing is writable from the host side only
    if (host_wr_route)
    begin
      st_d.route = host_wdata_sw;
    end

    // Message triggers: any value counts; a set in the same cycle
    // as the clearing read wins so no message is lost.
    if (host_rd_msg1)
    begin
      st_d.msg1_flag = 1'h0;
    end
    if (host_rd_msg2)
    begin
      st_d.msg2_flag = 1'h0;
    end
    if (cpu_wr_msg1)
    begin
      st_d.msg1_data = cpu_req.wdata;
      st_d.msg1_flag = 1'h1;
    end
    if (cpu_wr_msg2)
    begin
      st_d.msg2_data = cpu_req.wdata;
      st_d.msg2_flag = 1'h1;
    end

    // Incoming direction: host writes, CPU reads
    if (cpu_rd_mbx)
    begin
      st_d.in_flag        = 1'h0;
      st_d.cpu_irq.mbx_rx = 1'h0;
    end
    if (host_wr_mbx)
    begin
      st_d.mbx_in         = host_wdata_sw;
      st_d.in_flag        = 1'h1;
      // A disabled enable never wipes a receive irq that is already pending
      st_d.cpu_irq.mbx_rx = st_d.cpu_irq.mbx_rx | mbx_rx_irq_en;
    end

    // Outgoing direction: CPU writes, host reads
    if (cpu_wr_mbx)
    begin
      st_d.cpu_irq.mbx_tx = 1'h0;
    end
    if (host_rd_mbx)
    begin
      st_d.out_flag       = 1'h0;
      st_d.cpu_irq.mbx_tx = st_d.cpu_irq.mbx_tx | mbx_tx_irq_en;
    end
    if (cpu_wr_mbx)
    begin
      st_d.mbx_out  = cpu_req.wdata;
      st_d.out_flag = 1'h1;
    end

    // CPU read data; message triggers are write-only and read as zero
    if (cpu_req.rd)
    begin
      case (cpu_req.addr)
        `HPIRM_ADDR_ROUTE: st_d.cpu_rdata = st_q.route;
        `HPIRM_ADDR_MBX:   st_d.cpu_rdata = st_q.mbx_in;
        default:           st_d.cpu_rdata = 16'h0000;
      endcase
    end

    // Status reads only load the host read latch and leave CPU state alone
    if (host_req.rd || host_req.status_rd)
    begin
      st_d.host_rdata = host_raw_sw;
    end

    st_d.cpu_irq.eng = to_cpu(st_q.route, eng_evt);

    st_d.host_irq = (|to_host(st_q.route, eng_evt))
                  | st_d.msg1_flag | st_d.msg2_flag
                  | st_d.out_flag;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cpu_rdata     = st_q.cpu_rdata;
  assign host_rdata    = st_q.host_rdata;
  assign host_port_irq = st_q.host_irq;
  assign cpu_irq       = st_q.cpu_irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_sof_to_host: assert property (
    eng_evt.sof1 && st_q.route[`HPIRM_RT_SOF1_HOST] |=> host_port_irq)
    else $error("Routed frame irq did not reach host pin");

  a_sof_to_cpu: assert property (
    eng_evt.sof1 |=> cpu_irq.eng.sof1 == $past(st_q.route[`HPIRM_RT_SOF1_CPU]))
    else $error("Frame irq to CPU does not follow its enable");

  a_done_steer: assert property (
    eng_evt.done1 && st_q.route[`HPIRM_RT_DON1_HOST]
    |=> host_port_irq && !cpu_irq.eng.done1)
    else $error("Done irq not moved to host port");

  a_reset_steer: assert property (
    eng_evt.reset2 |=> cpu_irq.eng.reset2 != $past(st_q.route[`HPIRM_RT_RST2_HOST]))
    else $error("Reset irq steering wrong");

  a_msg_set: assert property (
    cpu_wr_msg1 |=> st_q.msg1_flag && host_port_irq ##1 host_port_irq || $past(host_rd_msg1))
    else $error("Message write did not flag the host");

  a_msg_clear: assert property (
    host_rd_msg2 && !cpu_wr_msg2 |=> !st_q.msg2_flag)
    else $error("Message flag not cleared by host read");

  a_mbx_rx: assert property (
    host_wr_mbx && mbx_rx_irq_en |=> cpu_irq.mbx_rx && st_q.in_flag)
    else $error("Host mailbox write did not raise receive irq");

  a_mbx_rx_clr: assert property (
    cpu_rd_mbx && !host_wr_mbx |=> !cpu_irq.mbx_rx && !st_q.in_flag)
    else $error("CPU mailbox read did not clear receive irq");

  a_mbx_tx: assert property (
    host_rd_mbx && mbx_tx_irq_en |=> cpu_irq.mbx_tx && !st_q.out_flag || $past(cpu_wr_mbx))
    else $error("Host mailbox read did not raise transmit irq");

  a_mbx_tx_clr: assert property (
    cpu_wr_mbx && !host_rd_mbx |=> !cpu_irq.mbx_tx && host_port_irq)
    else $error("CPU mailbox write did not clear transmit irq");

  a_route_ro: assert property (
    cpu_req.wr && !host_wr_route |=> $stable(st_q.route))
    else $error("CPU write changed the routing register");

  a_swap_lanes: assert property (
    host_req.status_rd && swap_en
    |=> host_rdata == {$past(status_word[7:0]), $past(status_word[15:8])})
    else $error("Swapped status lanes wrong");

  a_supply_bit: assert property (
    host_req.status_rd && !swap_en
    |=> host_rdata[`HPIRM_ST_SUPPLY] == $past(supply_valid_status))
    else $error("Supply valid status bit wrong");

  a_mbx_out_clr: assert property (
    host_rd_mbx && !cpu_wr_mbx |=> !st_q.out_flag)
    else $error("Host mailbox read did not clear outgoing flag");

  a_route_wr: assert property (
    host_wr_route |=> st_q.route == $past(host_wdata_sw))
    else $error("Host write did not load the routing register");

endmodule : hpirm_top

// *** testbench/hpirm_host_model.sv ***
// Behavioural external host processor on the parallel host port.
// Assumes every task is called from a falling edge of clock by the bench.
`timescale 1ns/1ns
module hpirm_host_model
(
  input  wire logic                  clock,
  output hpirm_pkg::hpirm_host_req_t host_req
);
  // Never clears engine interrupts, so the CPU alone owns that clear
  // Supply level is set by the bench ahead of each status read, so no settle wait is modelled
  initial host_req = '0;

  // Released address and data show the inverse, never a stale copy
  task automatic wr(input logic [15:0] a, input logic [15:0] w);
    @(negedge clock);
    host_req = '{rd: 1'b0, wr: 1'b1, status_rd: 1'b0, addr: a, wdata: w};
    @(negedge clock);
    host_req = '{rd: 1'b0, wr: 1'b0, status_rd: 1'b0, addr: ~a, wdata: ~w};
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic st);
    @(negedge clock);
    host_req = '{rd: !st, wr: 1'b0, status_rd: st, addr: a, wdata: ~host_req.wdata};
    @(negedge clock);
    host_req = '{rd: 1'b0, wr: 1'b0, status_rd: 1'b0, addr: ~a, wdata: host_req.wdata};
  endtask : rd
endmodule : hpirm_host_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the host port routing and mailbox block.
// Assumes the host model drives the host side and the bench the CPU side.
`timescale 1ns/1ns
`include "hpirm_cfg.svh"
module tb_top;
  logic                       clock;
  logic                       nrst;
  hpirm_pkg::hpirm_cpu_req_t  cpu_req;
  hpirm_pkg::hpirm_host_req_t host_req;
  hpirm_pkg::hpirm_eng_evt_t  eng_evt;
  hpirm_pkg::hpirm_cpu_irq_t  cpu_irq;
  logic [15:0]                cpu_rdata;
  logic [15:0]                host_rdata;
  logic [15:0]                rt;
  logic [15:0]                d;
  logic [15:0]                a;
  logic                       host_port_irq;
  logic                       rx_en;
  logic                       sup;
  logic                       idn;
  logic                       cpend;
  logic                       hpend;
  logic                       swp;
  logic [15:0]                cpu_q[$];
  logic [15:0]                host_q[$];
  integer                     seed;
  integer                     error_cnt;
  integer                     cmp_count;
  integer                     i;

  hpirm_top dut_u (.clock(clock), .nrst(nrst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .host_req(host_req), .host_rdata(host_rdata), .host_port_irq(host_port_irq),
    .eng_evt(eng_evt), .mbx_rx_irq_en(rx_en), .mbx_tx_irq_en(rx_en),
    .supply_valid_status(sup), .otg_identity_status(idn), .cpu_irq(cpu_irq));

  hpirm_host_model host_u (.clock(clock), .host_req(host_req));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop;
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Strobes are noted on the rising edge; read data is judged on the
  // following falling edge, once the register output has settled
  always @(posedge clock)
  begin
    cpend <= cpu_req.rd;
    hpend <= host_req.rd | host_req.status_rd;
  end

  always @(negedge clock)
  begin
    if (cpend)
      chk(cpu_rdata, cpu_q.pop_front());
    if (hpend)
      chk(host_rdata, host_q.pop_front());
  end

  task automatic cpu_wr(input logic [15:0] ad, input logic [15:0] w);
    @(negedge clock);
    cpu_req = '{rd: 1'b0, wr: 1'b1, addr: ad, wdata: w};
    @(negedge clock);
    cpu_req = '{rd: 1'b0, wr: 1'b0, addr: ~ad, wdata: ~w};
  endtask : cpu_wr

  task automatic cpu_rd(input logic [15:0] ad, input logic [15:0] e);
    cpu_q.push_back(e);
    @(negedge clock);
    cpu_req = '{rd: 1'b1, wr: 1'b0, addr: ad, wdata: ~cpu_req.wdata};
    @(negedge clock);
    cpu_req = '{rd: 1'b0, wr: 1'b0, addr: ~ad, wdata: cpu_req.wdata};
  endtask : cpu_rd

  task automatic hrd(input logic [15:0] ad, input logic [15:0] e);
    host_q.push_back(e);
    host_u.rd(ad, 1'b0);
  endtask : hrd

  // Status word from the flags the bench expects and fresh random pin levels
  // With swp set the expected word crosses exchanged lanes
  task automatic hst(input logic in, m2, m1, out, input logic [7:0] e);
    logic [15:0] w;
    sup = $random(seed);
    idn = $random(seed);
    w = {sup, idn, 1'b0, e[7], 1'b0, e[6], e[5], in, e[3], e[2], m2, m1,
      e[1], e[0], e[4], out};
    host_q.push_back(swp ? {w[7:0], w[15:8]} : w);
    host_u.rd(16'h0000, 1'b1);
  endtask : hst

  initial
  begin
    seed = 32'hf8ad;
    error_cnt = 0;
    cmp_count = 0;
    cpend = 1'b0;
    hpend = 1'b0;
    swp = 1'b0;
    nrst = 1'b0;
    cpu_req = '0;
    eng_evt = '0;
    rx_en = 1'b0;
    sup = 1'b0;
    idn = 1'b0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    cpu_rd(`HPIRM_ADDR_ROUTE, 16'h1400);
    cpu_wr(`HPIRM_ADDR_ROUTE, 16'hFFFF);
    cpu_rd(`HPIRM_ADDR_ROUTE, 16'h1400);
    cpu_rd(16'h0146, 16'h0000);
    cpu_rd(`HPIRM_ADDR_MSG1, 16'h0000);
    hrd(16'h0150, 16'h0000);
    hst(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    // Swap bits kept clear so routing words cross the lanes unchanged
    for (i = 0; i < 16; i++)
    begin
      rt = $random(seed) & 16'hFEFE;
      host_u.wr(`HPIRM_ADDR_ROUTE, rt);
      cpu_rd(`HPIRM_ADDR_ROUTE, rt);
      eng_evt = $random(seed);
      @(negedge clock);
      chk({15'h0000, host_port_irq}, {15'h0000, |(eng_evt & {rt[13], rt[11], rt[9], rt[1],
        rt[7], rt[6], rt[3], rt[2]})});
      chk({8'h00, cpu_irq.eng}, {8'h00, eng_evt & {rt[12], rt[10], ~rt[9], ~rt[1], ~rt[7],
        ~rt[6], ~rt[3], ~rt[2]}});
    end
    host_u.wr(`HPIRM_ADDR_ROUTE, 16'h2ACE);
    eng_evt = 8'hFF;
    hst(1'b0, 1'b0, 1'b0, 1'b0, 8'hFF);
    eng_evt = 8'h00;
    host_u.wr(`HPIRM_ADDR_ROUTE, 16'h1400);
    for (i = 0; i < 2; i++)
    begin
      a = i ? `HPIRM_ADDR_MSG2 : `HPIRM_ADDR_MSG1;
      d = $random(seed);
      cpu_wr(a, d);
      chk({15'h0000, host_port_irq}, 16'h0001);
      hst(1'b0, i[0], !i[0], 1'b0, 8'h00);
      hrd(a, d);
      chk({15'h0000, host_port_irq}, 16'h0000);
      hst(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    end
    for (i = 0; i < 2; i++)
    begin
      rx_en = i[0];
      d = $random(seed);
      host_u.wr(`HPIRM_ADDR_MBX, d);
      chk({15'h0000, cpu_irq.mbx_rx}, {15'h0000, i[0]});
      hst(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      cpu_rd(`HPIRM_ADDR_MBX, d);
      chk({15'h0000, cpu_irq.mbx_rx}, 16'h0000);
      cpu_wr(`HPIRM_ADDR_MBX, ~d);
      chk({15'h0000, host_port_irq}, 16'h0001);
      chk({15'h0000, cpu_irq.mbx_tx}, 16'h0000);
      hst(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
      hrd(`HPIRM_ADDR_MBX, ~d);
      chk({15'h0000, host_port_irq}, 16'h0000);
      chk({15'h0000, cpu_irq.mbx_tx}, {15'h0000, i[0]});
    end
    // Transmit irq is pending here, so the CPU write must really clear it
    cpu_wr(`HPIRM_ADDR_MBX, d);
    chk({15'h0000, cpu_irq.mbx_tx}, 16'h0000);
    hrd(`HPIRM_ADDR_MBX, d);
    host_u.wr(`HPIRM_ADDR_ROUTE, 16'h0101);
    host_u.wr(`HPIRM_ADDR_MBX, 16'h1234);
    swp = 1'b1;
    hst(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    swp = 1'b0;
    cpu_rd(`HPIRM_ADDR_MBX, 16'h3412);
    cpu_wr(`HPIRM_ADDR_MBX, 16'hABCD);
    hrd(`HPIRM_ADDR_MBX, 16'hCDAB);
    cpu_rd(`HPIRM_ADDR_ROUTE, 16'h0101);
    host_u.wr(`HPIRM_ADDR_ROUTE, 16'h0000);
    hrd(`HPIRM_ADDR_ROUTE, 16'h0000);
    repeat (3) @(negedge clock);
    report_and_stop();
  end

  initial
  begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top
